// *** common/msp_pkg.sv ***
/*
 * Shared constants and types for the meter serial port.
 * Assumes one 100 MHz clock; the host owns the serial clock.
 */
package msp_pkg;
   // Command byte layout.
   localparam int CMD_W = 8;
   localparam int CMD_RW_BIT = 7;
   localparam int ADDR_W = 7;
   // Data path: up to three bytes per register.
   localparam int BYTE_W = 8;
   localparam int MAX_BYTES = 3;
   localparam int DATA_W = BYTE_W * MAX_BYTES;
   localparam int CNT_W = 5;
   localparam int IDX_W = 2;
   // Register addresses handled inside the port.
   localparam logic [6:0] ADDR_OPERATING_CONTROL_REG = 7'h13;
   localparam logic [6:0] ADDR_STATUS = 7'h19;
   localparam logic [6:0] ADDR_STATUS_CLR = 7'h1A;
   localparam int OPERATING_CONTROL_REG_SWRST_BIT = 6;
   localparam logic [1:0] STATUS_LEN = 2'h3;
   // Status flag that follows rst_event each cycle and is never latched.
   localparam int RST_FLAG_BIT = 16;
   // Reset values.
   localparam logic [23:0] STATUS_RST = 24'h000000;
   localparam logic [4:0] CNT_ZERO = 5'h00;
   localparam logic [4:0] CNT_ONE = 5'h01;
   localparam logic [1:0] IDX_ZERO = 2'h0;
   localparam logic [1:0] IDX_ONE = 2'h1;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // Serial port modes.
   typedef enum logic [1:0]
   {
      MSP_CMD,
      MSP_FETCH,
      MSP_RD,
      MSP_WR
   } msp_state_e;

   // One register byte handed to the register file.
   typedef struct packed
   {
      logic [6:0] addr;
      logic [1:0] idx;
      logic [7:0] data;
   } msp_wr_s;
endpackage

// *** sim/msp_host_model.sv ***
/*
 * Host model that drives the serial link as bus master.
 * Assumes a 100 MHz clk; sclk halves of 6 and 7 clk give about 125 ns.
 */
`timescale 1ns/1ps
module msp_host_model (
   input wire logic clk, // System clock.
   output logic sclk, // Serial clock, idle high.
   output logic din, // Serial data to the port.
   output logic cs_b, // Chip select, active low.
   input wire logic dout, // Serial data from the port.
   input wire logic dout_oe_b // Low while dout is driven.
);
   initial
   begin
      sclk = 1'b1;
      din = 1'b1;
      cs_b = 1'b1;
   end
   // Sends nb bits of tx, MSB first, and returns what came back; gives up at bit ab.
   task automatic frame(input logic [31:0] tx, input int nb, input int ab, output logic [31:0] rx);
      rx = 'x;
      cs_b <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = nb - 1; i >= 0; i--)
      begin
         // An abort leaves the clock high and just lets go of select.
         if (nb - 1 - i == ab)
            break;
         din <= tx[i];
         repeat (6) @(posedge clk);
         rx[i] = dout_oe_b ? 1'bz : dout;
         sclk <= 1'b0;
         repeat (6 + i % 2) @(posedge clk);
         sclk <= 1'b1;
      end
      repeat (4) @(posedge clk);
      // A released line must not keep showing the last bit.
      din <= ~din;
      cs_b <= 1'b1;
      repeat (120) @(posedge clk);
   endtask
endmodule

// *** sim/msp_port_properties.sv ***
/*
 * Checker for the meter serial port, bound to its top module.
 * Assumes the serial pins are slow against clk.
 */
`timescale 1ns/1ps
module msp_port_properties
   import msp_pkg::*;
#(
   parameter int NUM_FLAGS = DATA_W
) (
   input wire logic clk, // Clock.
   input wire logic rst_b, // Reset, active low.
   input wire logic clk_en, // Run enable.
   input wire logic sclk_pin, // Serial clock.
   input wire logic din_pin, // Serial data in.
   input wire logic cs_b_pin, // Chip select.
   input wire logic dout_o, // Serial data out.
   input wire logic dout_oe_b, // Output enable.
   input wire logic irq_b, // Interrupt line.
   input wire logic [ADDR_W-1:0] reg_addr, // Address.
   input wire logic [DATA_W-1:0] rd_data, // Read data.
   input wire logic [1:0] reg_len, // Byte count.
   input wire msp_wr_s wr_info, // Written byte.
   input wire logic wr_stb, // Write strobe.
   input wire logic sw_reset, // Soft reset.
   input wire logic [NUM_FLAGS-1:0] event_in, // Events.
   input wire logic [NUM_FLAGS-1:0] mask_in, // Mask.
   input wire logic rst_event // Reset event.
);
   logic [2:0] s_r; // Own serial clock synchroniser.
   logic [3:0] rc_r; // Cycles since a rise, saturating.
   logic [3:0] fc_r; // Cycles since a fall, saturating.
   wire rise_w = s_r[1] & ~s_r[2]; // Rise seen.
   wire fall_w = ~s_r[1] & s_r[2]; // Fall seen.
   // The counters give the outputs a few cycles of slack behind the pins.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_r <= 3'h7;
         rc_r <= 4'hF;
         fc_r <= 4'hF;
      end
      else
      begin
         s_r <= {s_r[1:0], sclk_pin};
         rc_r <= rise_w ? 4'h0 : rc_r + {3'h0, rc_r != 4'hF};
         fc_r <= fall_w ? 4'h0 : fc_r + {3'h0, fc_r != 4'hF};
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // Chip select held high for a while.
   sequence s_idle;
      cs_b_pin [*5];
   endsequence
   // Clearing status command just decoded.
   sequence s_clr_cmd;
      $changed(reg_addr) && reg_addr == ADDR_STATUS_CLR && !cs_b_pin;
   endsequence
   a_cs_float: assert property (s_idle |-> dout_oe_b)
      else $error("dout driven while deselected");
   a_launch_rise: assert property (!dout_oe_b && $past(!dout_oe_b) && $changed(dout_o) |-> rc_r <= 4)
      else $error("dout changed away from a rise");
   a_float_fall: assert property ($rose(dout_oe_b) && !cs_b_pin |-> fc_r <= 4)
      else $error("dout released away from a fall");
   a_irq_release: assert property (s_clr_cmd |-> irq_b)
      else $error("irq low after clearing command");
   a_irq_hold: assert property (!dout_oe_b && reg_addr == ADDR_STATUS_CLR |-> irq_b)
      else $error("irq low during status data");
   a_irq_event: assert property (cs_b_pin && |(event_in & mask_in) |-> ##[1:3] !irq_b)
      else $error("masked event gave no irq");
   a_stb_single: assert property (wr_stb |=> !wr_stb [*8])
      else $error("write strobe too long");
   a_swrst_src: assert property (sw_reset |-> wr_info.addr == ADDR_OPERATING_CONTROL_REG && wr_info.data[OPERATING_CONTROL_REG_SWRST_BIT])
      else $error("soft reset without its write");
endmodule
bind msp_port msp_port_properties #(.NUM_FLAGS(NUM_FLAGS)) props_inst (.*);

// *** sim/tb_msp_port.sv ***
/*
 * Self-checking bench for the meter serial port.
 * Assumes the host model drives the link and this module the register side.
 */
`timescale 1ns/1ps
module tb_msp_port;
   import msp_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, flip = 1'b0;
   logic sclk_pin, din_pin, cs_b_pin, dout_o, dout_oe_b, irq_b, wr_stb, sw_reset;
   logic rst_event = 1'b0;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] rd_data, event_in = '0, mask_in = '0;
   logic [1:0] reg_len;
   logic [31:0] rx;
   msp_wr_s wr_info;
   msp_wr_s wq[$]; // Bytes written, in order.
   int errors = 0, num_checks = 0, nrst = 0;
   always #5 clk = ~clk;
   msp_port #(.NUM_FLAGS(DATA_W)) msp_port_inst (.*);
   msp_host_model msp_host_model_inst (.clk(clk), .sclk(sclk_pin), .din(din_pin), .cs_b(cs_b_pin),
      .dout(dout_o), .dout_oe_b(dout_oe_b));
   // Register contents made from the address, so every read is predictable.
   function automatic logic [23:0] val(input logic [6:0] a);
      return {1'b0, a, 8'hA5, 1'b1, a};
   endfunction
   // Register side follows the address at once, as the port fetches on the
   // edge after reg_addr moves; flip disturbs the contents.
   always_comb
   begin
      rd_data = val(reg_addr) ^ {24{flip}};
      reg_len = (reg_addr == ADDR_OPERATING_CONTROL_REG) ? 2'h1 : {1'b1, ~reg_addr[6]};
   end
   // Written bytes and soft resets are logged as they come out.
   always @(posedge clk)
   begin
      if (wr_stb === 1'b1)
         wq.push_back(wr_info);
      if (sw_reset === 1'b1)
         nrst++;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      if (errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // A hang anywhere ends the run as a failure.
   initial
   begin
      repeat (100000) @(posedge clk);
      errors++;
      wrap_up;
   end
   // Full write, then a write cut off inside its second byte.
   task automatic t_write;
      wq.delete();
      msp_host_model_inst.frame(32'hA1123456, 32, 99, rx);
      chk("wr count", wq.size(), 3);
      for (int k = 0; k < 3; k++)
         chk("wr byte", {wq[k].addr, wq[k].idx, wq[k].data}, {7'h21, k[1:0], 8'h12 + 8'h22 * k[7:0]});
      wq.delete();
      msp_host_model_inst.frame(32'hA1ABCDEF, 32, 20, rx);
      chk("abort count", wq.size(), 1);
      chk("abort byte", wq[0].data, 8'hAB);
   endtask
   // Soft reset fires only with its bit set.
   task automatic t_swrst;
      msp_host_model_inst.frame(32'h9340, 16, 99, rx);
      msp_host_model_inst.frame(32'h9300, 16, 99, rx);
      chk("soft reset", nrst, 1);
   endtask
   // Reads of three, two and one byte, one disturbed, one aborted.
   task automatic t_read;
      fork
         msp_host_model_inst.frame(32'h21000000, 32, 99, rx);
         begin
            repeat (250) @(posedge clk);
            flip <= 1'b1;
         end
      join
      flip <= 1'b0;
      chk("read3", rx[23:0], val(7'h21));
      msp_host_model_inst.frame(32'h4C0000, 24, 99, rx);
      chk("read2", rx[15:0], val(7'h4C) & 24'h00FFFF);
      msp_host_model_inst.frame(32'h1300, 16, 99, rx);
      chk("read1", rx[7:0], val(7'h13) & 24'h0000FF);
      chk("reg addr", reg_addr, 7'h13);
      msp_host_model_inst.frame(32'h21000000, 32, 14, rx);
      chk("abort read", rx[23:18], val(7'h21) >> 18);
      chk("float", dout_oe_b, 1);
   endtask
   // Status reads with events arriving before and during them.
   task automatic t_status;
      mask_in <= 24'h000008;
      event_in <= 24'h000028;
      @(posedge clk);
      event_in <= '0;
      repeat (4) @(posedge clk);
      chk("irq set", irq_b, 0);
      fork
         msp_host_model_inst.frame(32'h1A000000, 32, 99, rx);
         begin
            repeat (200) @(posedge clk);
            event_in <= 24'h000008;
            @(posedge clk);
            event_in <= '0;
         end
      join
      chk("flags", rx[23:0], 24'h000028);
      chk("irq pending", irq_b, 0);
      rst_event <= 1'b1;
      msp_host_model_inst.frame(32'h19000000, 32, 99, rx);
      rst_event <= 1'b0;
      chk("reset flag", rx[23:0], 24'h010008);
      msp_host_model_inst.frame(32'h1A000000, 32, 99, rx);
      chk("flags2", rx[23:0], 24'h000008);
      chk("irq idle", irq_b, 1);
      event_in <= 24'h000020;
      @(posedge clk);
      event_in <= '0;
      repeat (4) @(posedge clk);
      chk("unmasked", irq_b, 1);
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      t_write;
      t_swrst;
      t_read;
      t_status;
      wrap_up;
   end
endmodule

// *** src/msp_pin_sync.sv ***
/*
 * Two-flop synchroniser and edge finder for the serial pins.
 * Assumes pins are asynchronous to clk and slow against it.
 */
`timescale 1ns/1ps
module msp_pin_sync #(
   parameter int WIDTH = 3
) (
   input wire logic clk, // System clock.
   input wire logic rst_b, // Async reset, active low.
   input wire logic clk_en, // Freezes state when low.
   input wire logic [WIDTH-1:0] pin_in, // Raw pins.
   input wire logic [WIDTH-1:0] rst_val, // Idle level per pin.
   output logic [WIDTH-1:0] level, // Synchronised level.
   output logic [WIDTH-1:0] rise, // One-cycle rising pulse.
   output logic [WIDTH-1:0] fall // One-cycle falling pulse.
);
   // The stages hold each pin relative to its idle level, so the all-zero
   // reset state means idle and no false edge follows reset.
   generate
      for (genvar i = 0; i < WIDTH; i++)
      begin : g_bit
         logic meta_r; // First stage, read by the second only.
         logic sync_r; // Second stage.
         logic last_r; // Previous synced value.
         // The first stage only feeds the second, so metastability
         // never reaches the edge compare.
         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               meta_r <= 1'b0;
               sync_r <= 1'b0;
               last_r <= 1'b0;
            end
            else if (clk_en)
            begin
               meta_r <= pin_in[i] ^ rst_val[i];
               sync_r <= meta_r;
               last_r <= sync_r;
            end
         end
         assign level[i] = sync_r ^ rst_val[i];
         assign rise[i] = clk_en & (sync_r ^ last_r) & level[i];
         assign fall[i] = clk_en & (sync_r ^ last_r) & ~level[i];
      end
   endgenerate
endmodule

// *** src/msp_port.sv ***
/*
 * Serial slave port of the metering device with interrupt line.
 * Assumes the register file answers rd_data in the cycle after
 * reg_addr changes, and that the host keeps its own timing gaps.
 */
// What this block does
// - Clearing status read raises interrupt after command.
// - Interrupt stays high through status data.
// - After status data, interrupt reflects pending events.
// - Input data sampled on serial clock fall.
// - Output bits launched on serial clock rise.
// - Chip select fall restarts in command mode.
// - Chip select rise aborts and floats output.
// - Otherwise only a finished transfer restores command mode.
// - First byte always goes to command register.
// - Top bit write/read, low seven address.
// - Transfer ends after last bit moves.
// - Write data captured on following falling edges.
// - Aborted write byte is never stored.
// - Up to three bytes, MSB first, right-justified.
// - Read drives first bit on next rise.
// - Output floats on last read falling edge.
// - Chip select rise floats read output.
// - Read register copied whole into shifter.
// - Reset flag follows the reset event each cycle, never latched.
// - Flags set always; mask gates interrupt.
// - Clearing status read returns and clears flags.
`timescale 1ns/1ps
module msp_port
   import msp_pkg::*;
#(
   parameter int NUM_FLAGS = msp_pkg::DATA_W
) (
   input wire logic clk, // 100 MHz system clock.
   input wire logic rst_b, // Async reset, active low.
   input wire logic clk_en, // Freezes all state when low.
   input wire logic sclk_pin, // Serial clock from host.
   input wire logic din_pin, // Serial data from host.
   input wire logic cs_b_pin, // Chip select, active low.
   output logic dout_o, // Serial data to host.
   output logic dout_oe_b, // Low while dout is driven.
   output logic irq_b, // Interrupt line, active low.
   output logic [msp_pkg::ADDR_W-1:0] reg_addr, // Addressed register.
   input wire logic [msp_pkg::DATA_W-1:0] rd_data, // Register contents.
   input wire logic [1:0] reg_len, // Byte count of reg_addr.
   output msp_pkg::msp_wr_s wr_info, // Written byte and place.
   output logic wr_stb, // One-cycle pulse per byte.
   output logic sw_reset, // Software reset pulse.
   input wire logic [NUM_FLAGS-1:0] event_in, // Event pulses.
   input wire logic [NUM_FLAGS-1:0] mask_in, // Interrupt mask.
   input wire logic rst_event // Reset event pulse.
);
   // Refuse widths the status path cannot carry.
   initial
   begin
      if (NUM_FLAGS != DATA_W)
      begin
         $error("msp_port: NUM_FLAGS must equal DATA_W");
      end
   end

   // Synchronised pin levels and edges, bit 0 sclk, 1 din, 2 cs.
   logic [2:0] pin_lvl;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;

   msp_pin_sync #(
      .WIDTH(3)
   ) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .pin_in({cs_b_pin, din_pin, sclk_pin}),
      .rst_val(3'h5),
      .level(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // Named views of the synchronised pins.
   wire din_s = pin_lvl[1];
   wire cs_active = ~pin_lvl[2];
   wire cs_fall = pin_fall[2];
   wire cs_rise = pin_rise[2];
   // Serial edges count only while chip select is low.
   wire sclk_rise = pin_rise[0] & cs_active;
   wire sclk_fall = pin_fall[0] & cs_active;

   // Port state.
   msp_state_e state_r; // Current mode.
   msp_state_e state_nxt; // Next mode.
   logic [CNT_W-1:0] bit_cnt_r; // Bits moved in this phase.
   logic [CNT_W-1:0] bit_cnt_nxt;
   logic [DATA_W-1:0] shift_r; // Shift buffer.
   logic [DATA_W-1:0] shift_nxt;
   logic [1:0] len_r; // Bytes in current register.
   logic [1:0] len_nxt;
   logic is_read_r; // Command was a read.
   logic is_read_nxt;
   logic [ADDR_W-1:0] addr_r; // Target register index.
   logic [ADDR_W-1:0] addr_nxt;
   logic [NUM_FLAGS-1:0] status_r; // Latched event flags.
   logic [NUM_FLAGS-1:0] status_nxt;
   logic irq_hold_r; // Forces the line high.
   logic irq_hold_nxt;
   logic irq_b_nxt;
   logic dout_nxt;
   logic dout_oe_b_nxt;
   logic wr_stb_nxt;
   msp_wr_s wr_info_nxt;
   logic sw_reset_nxt;

   // Command byte decode, valid on the eighth falling edge.
   wire [CMD_W-1:0] cmd_byte = {shift_r[CMD_W-2:0], din_s};
   wire cmd_write = cmd_byte[CMD_RW_BIT];
   wire [ADDR_W-1:0] cmd_target_reg_index = cmd_byte[ADDR_W-1:0];
   wire byte_last_bit = (bit_cnt_r[2:0] == 3'h7);
   wire [BYTE_W-1:0] wr_byte = {shift_r[BYTE_W-2:0], din_s};

   // Status reads are answered here, others by the register file.
   wire status_hit = (addr_r == ADDR_STATUS) |
                     (addr_r == ADDR_STATUS_CLR);
   wire clr_hit = (addr_r == ADDR_STATUS_CLR);
   wire [1:0] fetch_len = status_hit ? STATUS_LEN : reg_len;
   // A zero length is served as one byte so the port cannot hang.
   wire [1:0] fetch_len_safe = (fetch_len == IDX_ZERO) ?
                               IDX_ONE : fetch_len;
   wire [DATA_W-1:0] fetch_word = status_hit ? status_r : rd_data;
   // Right-justified word is moved up so its top byte leads.
   wire [4:0] fetch_pad = 5'(BYTE_W * (MAX_BYTES - fetch_len_safe));
   wire [DATA_W-1:0] fetch_aligned = fetch_word << fetch_pad;
   // Total bits in the data phase.
   wire [CNT_W-1:0] data_bits = 5'(BYTE_W * len_r);
   wire rd_last_fall = (bit_cnt_r == data_bits - CNT_ONE);
   wire [1:0] wr_idx_now = 2'(bit_cnt_r >> 3);
   wire wr_done = (wr_idx_now == len_r - IDX_ONE);
   wire swrst_hit = (addr_r == ADDR_OPERATING_CONTROL_REG) &
                    wr_byte[OPERATING_CONTROL_REG_SWRST_BIT];

   // Flags: a new event always wins over a clearing read.
   wire status_clear = (state_r == MSP_FETCH) & clr_hit;
   wire [NUM_FLAGS-1:0] status_keep = status_clear ?
                                      STATUS_RST : status_r;
   wire pending = |(status_r & mask_in);

   // Next-state logic for the serial engine.
   always_comb
   begin
      state_nxt = state_r;
      bit_cnt_nxt = bit_cnt_r;
      shift_nxt = shift_r;
      len_nxt = len_r;
      is_read_nxt = is_read_r;
      addr_nxt = addr_r;
      irq_hold_nxt = irq_hold_r;
      dout_nxt = dout_o;
      dout_oe_b_nxt = dout_oe_b;
      wr_stb_nxt = 1'b0;
      wr_info_nxt = wr_info;
      sw_reset_nxt = 1'b0;
      if (cs_fall | cs_rise)
      begin
         state_nxt = MSP_CMD;
         bit_cnt_nxt = CNT_ZERO;
         dout_oe_b_nxt = 1'b1;
         irq_hold_nxt = 1'b0;
      end
      else
      begin
         case (state_r)
            MSP_CMD:
            begin
               if (sclk_fall)
               begin
                  shift_nxt = {shift_r[DATA_W-2:0], din_s};
                  bit_cnt_nxt = bit_cnt_r + CNT_ONE;
                  if (bit_cnt_r == CNT_W'(CMD_W - 1))
                  begin
                     bit_cnt_nxt = CNT_ZERO;
                     is_read_nxt = ~cmd_write;
                     addr_nxt = cmd_target_reg_index;
                     state_nxt = MSP_FETCH;
                     if (!cmd_write && cmd_target_reg_index == ADDR_STATUS_CLR)
                     begin
                        irq_hold_nxt = 1'b1;
                     end
                  end
               end
            end
            MSP_FETCH:
            begin
               len_nxt = fetch_len_safe;
               shift_nxt = fetch_aligned;
               state_nxt = is_read_r ? MSP_RD : MSP_WR;
            end
            MSP_RD:
            begin
               if (sclk_rise)
               begin
                  dout_nxt = shift_r[DATA_W-1];
                  dout_oe_b_nxt = 1'b0;
                  shift_nxt = {shift_r[DATA_W-2:0], 1'b0};
               end
               else if (sclk_fall)
               begin
                  bit_cnt_nxt = bit_cnt_r + CNT_ONE;
                  if (rd_last_fall)
                  begin
                     state_nxt = MSP_CMD;
                     bit_cnt_nxt = CNT_ZERO;
                     dout_oe_b_nxt = 1'b1;
                     irq_hold_nxt = 1'b0;
                  end
               end
            end
            MSP_WR:
            begin
               if (sclk_fall)
               begin
                  shift_nxt = {shift_r[DATA_W-2:0], din_s};
                  bit_cnt_nxt = bit_cnt_r + CNT_ONE;
                  if (byte_last_bit)
                  begin
                     wr_stb_nxt = 1'b1;
                     wr_info_nxt.addr = addr_r;
                     wr_info_nxt.idx = wr_idx_now;
                     wr_info_nxt.data = wr_byte;
                     if (wr_done)
                     begin
                        state_nxt = MSP_CMD;
                        bit_cnt_nxt = CNT_ZERO;
                        sw_reset_nxt = swrst_hit;
                     end
                  end
               end
            end
            default:
            begin
               state_nxt = MSP_CMD;
               bit_cnt_nxt = CNT_ZERO;
            end
         endcase
      end
   end

   // Status flags and interrupt line.
   always_comb
   begin
      status_nxt = status_keep | event_in;
      status_nxt[RST_FLAG_BIT] = rst_event;
      irq_b_nxt = irq_hold_nxt | ~pending;
   end

   // Serial engine registers.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r <= MSP_CMD;
         bit_cnt_r <= CNT_ZERO;
         shift_r <= STATUS_RST;
         len_r <= IDX_ONE;
         is_read_r <= 1'b0;
         addr_r <= 7'h00;
      end
      else if (clk_en)
      begin
         state_r <= state_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         shift_r <= shift_nxt;
         len_r <= len_nxt;
         is_read_r <= is_read_nxt;
         addr_r <= addr_nxt;
      end
   end

   // Output pins and interrupt state.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dout_o <= 1'b0;
         dout_oe_b <= 1'b1;
         irq_b <= 1'b1;
         irq_hold_r <= 1'b0;
         status_r <= STATUS_RST;
      end
      else if (clk_en)
      begin
         dout_o <= dout_nxt;
         dout_oe_b <= dout_oe_b_nxt;
         irq_b <= irq_b_nxt;
         irq_hold_r <= irq_hold_nxt;
         status_r <= status_nxt;
      end
   end

   // Register file side, all straight from flops.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reg_addr <= 7'h00;
         wr_stb <= 1'b0;
         wr_info <= '0;
         sw_reset <= 1'b0;
      end
      else if (clk_en)
      begin
         reg_addr <= addr_nxt;
         wr_stb <= wr_stb_nxt;
         wr_info <= wr_info_nxt;
         sw_reset <= sw_reset_nxt;
      end
   end
endmodule
